// [common/e1txf_pkg.sv]
// Constants and types for the E1 transmit format control block
package e1txf_pkg;
  localparam int CLK_PERIOD_NS = 4;
  localparam int BIT_PERIOD_NS = 488;
  localparam int BIT_DIV_CYC = (BIT_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FIFO_DEPTH = 4;
  localparam int BYTE_W = 8;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_TC1 = 6'h12;
  localparam logic [5:0] IDX_TC2 = 6'h13;
  localparam logic [5:0] IDX_ALIGN = 6'h20;
  localparam logic [5:0] IDX_NALIGN = 6'h21;
  localparam logic [5:0] IDX_STATUS = 6'h22;
  localparam logic [5:0] IDX_SIG_BASE = 6'h30;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] ALL_ONES = 8'hFF;
  localparam logic [4:0] SLOT_FAS = 5'h00;
  localparam logic [4:0] SLOT_SIG = 5'h10;
  localparam logic [4:0] SLOT_LAST = 5'h1F;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [3:0] FRAME_EBIT_A = 4'hD;
  localparam logic [3:0] FRAME_EBIT_B = 4'hF;
  localparam int SI_POS = 7;

  typedef struct packed {
    logic line_output_format;
    logic slot_zero_pass_through;
    logic slot_sixteen_source_select;
    logic unframed_ones_force;
    logic international_bit_source;
    logic signaling_ones_force;
    logic tx_sync_mode_select;
    logic tx_sync_direction;
  } e1txf_ctl1_t;

  typedef struct packed {
    logic [4:0] spare_bit_select;
    logic pulse_width_mode;
    logic auto_ebit_enable;
    logic alarm_pin_function;
  } e1txf_ctl2_t;

  typedef enum logic [1:0] {
    AP_IDLE = 2'b01,
    AP_DONE = 2'b10
  } e1txf_apst_t;
endpackage

// [core/e1txf_core.sv]
// E1 transmit formatter with its control registers and backplane FIFO
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps

// Byte FIFO between the serial assembler and the formatter
module e1txf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } e1txf_fst_t;
  e1txf_fst_t s, n;
  logic wr, rd;

  // Pointers wrap at 2**AW, not at DEPTH, so depth should be a power of two
  always_comb begin
    n = s;
    wr = in_valid && in_ready;
    rd = out_valid && out_ready;
    if (wr) begin
      n.mem[s.wp] = in_data;
      n.wp = s.wp + 1'b1;
    end
    if (rd) n.rp = s.rp + 1'b1;
    n.cnt = s.cnt + (AW+1)'(wr) - (AW+1)'(rd);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) s <= '0;
    else s <= n;
  end

  assign in_ready = s.cnt != (AW+1)'(DEPTH);
  assign out_valid = s.cnt != '0;
  assign out_data = s.mem[s.rp];
endmodule

module e1txf_core import e1txf_pkg::*; #(
  parameter int BIT_DIV = BIT_DIV_CYC
) (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic BACKPLANE_SERIAL_IN,
  output logic LINE_OUT_POSITIVE,
  output logic LINE_OUT_NEGATIVE,
  output logic LINE_OUT_CLOCK,
  input wire logic TX_FRAME_MARKER_IN,
  output logic TX_FRAME_MARKER_OUT,
  output logic TX_FRAME_MARKER_OE_N
);
  localparam int HALF = BIT_DIV / 2;

  typedef struct packed {
    e1txf_apst_t ap;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    e1txf_ctl1_t tc1;
    e1txf_ctl2_t tc2;
    e1txf_ctl1_t tc1_act;
    e1txf_ctl2_t tc2_act;
    logic [7:0] align;
    logic [7:0] nalign;
    logic [15:0][7:0] sig;
    logic [7:0] cnt;
    logic [2:0] bitn;
    logic [4:0] slot;
    logic [3:0] frame;
    logic [7:0] shin;
    logic [2:0] nin;
    logic push;
    logic [7:0] out_byte;
    logic ami_neg;
    logic lvl_pos;
    logic lvl_neg;
    logic pos;
    logic neg;
    logic lclk;
    logic mark_out;
    logic mark_oe_n;
    logic mark_in_q;
  } e1txf_st_t;

  e1txf_st_t s, n;
  logic fifo_ready, fifo_valid, pop, tick, mark_edge, bitv;
  logic [7:0] fifo_data;
  logic [5:0] idx;
  logic [8:0] rdv;

  // Register read mux; unmapped indices flag an error
  function automatic logic [8:0] rd_reg(input e1txf_st_t st, input logic [5:0] i);
    rd_reg = {1'b0, REG_RESET};
    if (i == IDX_TC1) rd_reg[7:0] = st.tc1;
    else if (i == IDX_TC2) rd_reg[7:0] = st.tc2;
    else if (i == IDX_ALIGN) rd_reg[7:0] = st.align;
    else if (i == IDX_NALIGN) rd_reg[7:0] = st.nalign;
    else if (i == IDX_STATUS) rd_reg[7:0] = {st.slot[3:0], st.frame};
    else if (i[5:4] == IDX_SIG_BASE[5:4]) rd_reg[7:0] = st.sig[i[3:0]];
    else rd_reg[8] = 1'b1;
  endfunction

  // Builds one outgoing timeslot byte from its sources
  function automatic logic [7:0] compose(input e1txf_st_t st, input logic [7:0] ser,
                                         input logic [4:0] sl, input logic [3:0] fr);
    logic [7:0] reg0;
    reg0 = fr[0] ? st.nalign : st.align;
    compose = ser;
    if (sl == SLOT_FAS) begin
      if (!st.tc1_act.slot_zero_pass_through) compose = reg0;
      compose[SI_POS] = st.tc1_act.international_bit_source ? reg0[SI_POS] : ser[SI_POS];
      if (st.tc2_act.auto_ebit_enable && (fr == FRAME_EBIT_A || fr == FRAME_EBIT_B))
        compose[SI_POS] = 1'b1;
    end else if (sl == SLOT_SIG) begin
      if (st.tc1_act.slot_sixteen_source_select) compose = st.sig[fr];
      if (st.tc1_act.signaling_ones_force) compose = ALL_ONES;
    end
  endfunction

  e1txf_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(CORE_CLK),
    .rst(RESET),
    .in_valid(s.push),
    .in_ready(fifo_ready),
    .in_data(s.shin),
    .out_valid(fifo_valid),
    .out_ready(pop),
    .out_data(fifo_data)
  );

  always_comb begin
    n = s;
    idx = PADDR[7:2];
    // Bit 8 of the read mux flags an unmapped index
    rdv = rd_reg(s, idx);
    tick = s.cnt == 8'(BIT_DIV - 1);
    pop = tick && s.bitn == BIT_LAST;
    mark_edge = TX_FRAME_MARKER_IN && !s.mark_in_q && !s.tc1_act.tx_sync_direction;
    n.mark_in_q = TX_FRAME_MARKER_IN;
    bitv = 1'b0;
    // APB slave: one wait state, write lands on the pready edge
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    unique case (s.ap)
      AP_IDLE: begin
        if (PSEL && PENABLE) begin
          n.pready = 1'b1;
          n.pslverr = rdv[8];
          n.prdata = PWRITE ? 32'h0 : {24'h0, rdv[7:0]};
          n.ap = AP_DONE;
        end
      end
      AP_DONE: begin
        n.ap = AP_IDLE;
        n.prdata = 32'h0;
        if (PSEL && PENABLE && PWRITE && !s.pslverr) begin
          if (idx == IDX_TC1) n.tc1 = PWDATA[7:0];
          else if (idx == IDX_TC2) n.tc2 = PWDATA[7:0];
          else if (idx == IDX_ALIGN) n.align = PWDATA[7:0];
          else if (idx == IDX_NALIGN) n.nalign = PWDATA[7:0];
          else if (idx[5:4] == IDX_SIG_BASE[5:4]) n.sig[idx[3:0]] = PWDATA[7:0];
        end
      end
    endcase
    // Bit timing; an incoming marker realigns the frame
    n.cnt = tick ? 8'h00 : s.cnt + 8'h01;
    if (tick) begin
      n.bitn = s.bitn + 3'h1;
      if (pop) begin
        n.slot = s.slot + 5'h01;
        if (s.slot == SLOT_LAST) n.frame = s.frame + 4'h1;
      end
    end
    // marker input resets frame or multiframe
    if (mark_edge) begin
      n.cnt = 8'h00;
      n.bitn = 3'h0;
      n.slot = SLOT_FAS;
      if (s.tc1_act.tx_sync_mode_select) n.frame = 4'h0;
    end
    // controls change only at a frame boundary
    if (n.bitn == 3'h0 && n.slot == SLOT_FAS && n.cnt == 8'h00) begin
      n.tc1_act = s.tc1;
      n.tc2_act = s.tc2;
    end
    // Serial assembler; a full FIFO stalls it and bits are skipped
    if (s.push && fifo_ready) n.push = 1'b0;
    if (tick && !s.push) begin
      n.shin = {s.shin[6:0], BACKPLANE_SERIAL_IN};
      n.nin = s.nin + 3'h1;
      n.push = s.nin == BIT_LAST;
    end
    // Backplane leads the line by two timeslots; an empty FIFO sends ones
    if (pop) n.out_byte = compose(n, fifo_valid ? fifo_data : ALL_ONES, n.slot, n.frame);
    if (tick || mark_edge) begin
      bitv = n.out_byte[3'h7 - n.bitn];
      if (n.tc1_act.unframed_ones_force) bitv = 1'b1;
      if (n.tc1_act.line_output_format) begin
        n.lvl_pos = bitv;
        n.lvl_neg = 1'b0;
      end else begin
        n.lvl_pos = bitv && !s.ami_neg;
        n.lvl_neg = bitv && s.ami_neg;
        n.ami_neg = s.ami_neg ^ bitv;
      end
    end
    // half-width pulses drop at mid bit
    n.pos = n.lvl_pos && (!n.tc2_act.pulse_width_mode || n.cnt < 8'(HALF));
    n.neg = n.lvl_neg && (!n.tc2_act.pulse_width_mode || n.cnt < 8'(HALF));
    n.lclk = n.cnt < 8'(HALF);
    // marker pin direction; enable is active low
    n.mark_oe_n = !n.tc1_act.tx_sync_direction;
    n.mark_out = n.tc1_act.tx_sync_direction && n.slot == SLOT_FAS && n.bitn == 3'h0
                 && (!n.tc1_act.tx_sync_mode_select || n.frame == 4'h0);
  end

  // All state in one register
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      s <= '0;
      s.ap <= AP_IDLE;
      s.mark_oe_n <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign PRDATA = s.prdata;
  assign PREADY = s.pready;
  assign PSLVERR = s.pslverr;
  assign LINE_OUT_POSITIVE = s.pos;
  assign LINE_OUT_NEGATIVE = s.neg;
  assign LINE_OUT_CLOCK = s.lclk;
  assign TX_FRAME_MARKER_OUT = s.mark_out;
  assign TX_FRAME_MARKER_OE_N = s.mark_oe_n;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);

  nrz_neg_low_a: assert property (s.tc1_act.line_output_format |-> !s.neg)
    else $error("negative output high in NRZ mode");
  slot0_internal_a: assert property (
    s.slot == SLOT_FAS && !s.tc1_act.slot_zero_pass_through && !s.frame[0]
    && s.bitn == 3'h0 && s.cnt == 8'h00
    |-> s.out_byte[6:0] == s.align[6:0]) else $error("slot zero not from align register");
  sig_source_a: assert property (
    s.slot == SLOT_SIG && s.tc1_act.slot_sixteen_source_select
    && !s.tc1_act.signaling_ones_force |-> s.out_byte == s.sig[s.frame])
    else $error("slot sixteen not from signaling register");
  unframed_ones_a: assert property ($past(tick) && s.tc1_act.unframed_ones_force
    && $past(s.tc1_act.unframed_ones_force) |-> s.pos || s.neg)
    else $error("no pulse while unframed ones forced");
  si_internal_a: assert property (
    s.slot == SLOT_FAS && s.tc1_act.international_bit_source && !s.frame[0]
    && s.bitn == 3'h0 && s.cnt == 8'h00
    && !s.tc2_act.auto_ebit_enable |-> s.out_byte[SI_POS] == s.align[SI_POS])
    else $error("Si bit not from register");
  sig_ones_a: assert property (
    s.slot == SLOT_SIG && s.tc1_act.signaling_ones_force |-> s.out_byte == ALL_ONES)
    else $error("slot sixteen not all ones");
  mf_marker_a: assert property (
    s.mark_out && s.tc1_act.tx_sync_mode_select |-> s.frame == 4'h0 && s.slot == SLOT_FAS)
    else $error("multiframe marker outside frame zero");
  dir_oe_a: assert property (s.mark_out |-> !s.mark_oe_n)
    else $error("marker driven while pin is input");
  half_pulse_a: assert property (
    s.tc2_act.pulse_width_mode && s.cnt >= 8'(HALF) |-> !s.pos && !s.neg)
    else $error("pulse longer than half a bit");
  ebit_set_a: assert property (
    s.slot == SLOT_FAS && s.tc2_act.auto_ebit_enable && s.frame == FRAME_EBIT_A
    |-> s.out_byte[SI_POS]) else $error("E-bit not set");
  tc1_write_a: assert property (
    s.pready && PSEL && PENABLE && PWRITE && idx == IDX_TC1
    |=> s.tc1 == $past(PWDATA[7:0])) else $error("control one not written");
  act_boundary_a: assert property (
    !$stable(s.tc1_act) |-> s.slot == SLOT_FAS && s.bitn == 3'h0 && s.cnt == 8'h00)
    else $error("control change away from frame boundary");

  apb_write_c: cover property (s.pready && PWRITE && idx == IDX_TC1);
  multiframe_c: cover property (s.slot == SLOT_LAST && s.frame == 4'hF && pop);
  marker_in_c: cover property (mark_edge);
  fifo_stall_c: cover property (s.push && !fifo_ready);
endmodule

// [testbench/e1txf_lim.sv]
// Line interface model that decodes the transmit line symbols
`timescale 1ns/1ps
module e1txf_lim (
  input wire logic clk,
  input wire logic clr,
  input wire logic pos,
  input wire logic neg,
  input wire logic lclk,
  output int bits,
  output int marks,
  output int negs,
  output int viol,
  output int run_max
);
  logic lclk_q;
  logic pol_q;
  int run;

  // One symbol per bit start; the longest positive run gives the pulse width
  always @(posedge clk) begin
    lclk_q <= lclk;
    run <= pos ? run + 1 : 0;
    if (clr) begin
      {bits, marks, negs, viol, run_max} <= '0;
    end else begin
      if (pos && run >= run_max) begin
        run_max <= run + 1;
      end
      if (lclk && !lclk_q) begin
        bits <= bits + 1;
        marks <= marks + int'(pos | neg);
        negs <= negs + int'(neg);
        if ((pos && neg) || ((pos | neg) && neg == pol_q)) begin
          viol <= viol + 1;
        end
        if (pos | neg) begin
          pol_q <= neg;
        end
      end
    end
  end
endmodule

// [testbench/tb_top.sv]
// Self-checking testbench for the E1 transmit format control block
`timescale 1ns/1ps
module tb_top;
  import e1txf_pkg::*;
  localparam int DIV = 4;
  localparam int FRM = 256 * DIV;
  logic CORE_CLK = 1'b0;
  logic RESET = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h00000000;
  logic BACKPLANE_SERIAL_IN = 1'b0;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, pos, neg, lclk, mk_out, mk_oe_n, mk_q;
  logic ser_en = 1'b1;
  logic clr = 1'b1;
  logic [31:0] rng = 32'h00002B64;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  int fail_count = 0;
  int total_checks = 0;
  int bits, marks, negs, viol, run_max, rises;

  always #2 CORE_CLK = ~CORE_CLK;

  e1txf_core #(.BIT_DIV(DIV)) dut_u (.CORE_CLK(CORE_CLK), .RESET(RESET),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .BACKPLANE_SERIAL_IN(BACKPLANE_SERIAL_IN), .LINE_OUT_POSITIVE(pos),
    .LINE_OUT_NEGATIVE(neg), .LINE_OUT_CLOCK(lclk), .TX_FRAME_MARKER_IN(1'b0),
    .TX_FRAME_MARKER_OUT(mk_out), .TX_FRAME_MARKER_OE_N(mk_oe_n));

  e1txf_lim lim_u (.clk(CORE_CLK), .clr(clr), .pos(pos), .neg(neg), .lclk(lclk),
    .bits(bits), .marks(marks), .negs(negs), .viol(viol), .run_max(run_max));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // Random serial bits, gated off where frame content is counted
  always @(posedge CORE_CLK) begin
    rng <= xs(rng);
    BACKPLANE_SERIAL_IN <= ser_en & rng[0];
    mk_q <= mk_out;
    rises <= clr ? 0 : rises + int'(mk_out && !mk_q);
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string msg);
    total_checks++;
    if (seen !== want) begin
      fail_count++;
      $display("BAD %0t %s: got %0h want %0h", $time, msg, seen, want);
    end
  endtask

  task automatic wrap_up();
    $display("Totals: %0d compares, %0d mismatches", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // APB transfer; the expected answer is queued before the request goes out
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] wd,
                     input logic err);
    int n;
    n = 0;
    exp_q.push_back({wr, err, 24'h000000, err ? 8'h00 : wd});
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= {idx, 2'b00};
    PWDATA <= {rng[31:8], wd};
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CORE_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail_count++;
      wrap_up();
    end
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CORE_CLK);
  endtask

  // Answers are taken off the queue in order as they appear
  always @(posedge CORE_CLK) begin
    if (PREADY === 1'b1) begin
      e = exp_q.size() > 0 ? exp_q.pop_front() : 34'h3FFFFFFFF;
      check({31'h0, PSLVERR}, {31'h0, e[32]}, "error flag");
      if (!e[33]) check(PRDATA, e[31:0], "read data");
    end
  end

  // Program both controls, let a frame boundary pass, then count nf frames
  task automatic measure(input logic [7:0] c1, input logic [7:0] c2, input int nf);
    apb(1'b1, IDX_TC1, c1, 1'b0);
    apb(1'b1, IDX_TC2, c2, 1'b0);
    repeat (FRM + 8) @(posedge CORE_CLK);
    clr <= 1'b1;
    @(posedge CORE_CLK);
    clr <= 1'b0;
    repeat (nf * FRM) @(posedge CORE_CLK);
    // Read the counters once the last counted edge has settled
    @(negedge CORE_CLK);
    check({31'h0, mk_oe_n}, {31'h0, ~c1[0]}, "marker enable");
    if (c1[0]) check(rises, c1[1] ? nf / 16 : nf, "marker count");
    check(bits, nf * 256, "bit count");
  endtask

  initial begin
    logic [7:0] v;
    int b;
    repeat (5) @(posedge CORE_CLK);
    RESET <= 1'b0;
    clr <= 1'b0;
    @(posedge CORE_CLK);
    apb(1'b0, IDX_TC1, REG_RESET, 1'b0);
    apb(1'b0, IDX_TC2, REG_RESET, 1'b0);
    apb(1'b1, 6'h05, 8'hA5, 1'b1);
    apb(1'b0, 6'h05, 8'h00, 1'b1);
    for (int i = 0; i < 4; i++) begin
      // pass-through kept clear while Si comes from registers
      v = rng[15:8];
      if (v[3]) v[6] = 1'b0;
      apb(1'b1, IDX_TC1, v, 1'b0);
      apb(1'b0, IDX_TC1, v, 1'b0);
      // alarm pin bit written as zero
      v = rng[23:16] & 8'hFE;
      apb(1'b1, IDX_TC2, v, 1'b0);
      apb(1'b0, IDX_TC2, v, 1'b0);
    end
    $display("Test registers done");
    measure(8'h11, 8'h00, 2);
    check(marks, bits, "ones marks");
    check(viol < 2, 1, "polarity order");
    check(run_max, DIV, "full width");
    measure(8'h91, 8'h00, 2);
    check(negs, 0, "nrz negative low");
    check(marks, bits, "nrz ones");
    measure(8'h11, 8'h04, 2);
    check(run_max, DIV / 2, "half width");
    $display("Test line format done");
    // Quiet serial input so that only register-sourced bits make marks
    ser_en <= 1'b0;
    apb(1'b1, IDX_ALIGN, 8'h9B, 1'b0);
    apb(1'b1, IDX_NALIGN, 8'hC0, 1'b0);
    measure(8'h21, 8'h00, 2);
    b = marks;
    measure(8'h25, 8'h00, 2);
    check(marks, b + 16, "signaling ones");
    measure(8'h29, 8'h00, 2);
    check(marks, b + 2, "si from registers");
    measure(8'h41, 8'h00, 2);
    check(marks, b - 5, "slot zero pass");
    for (int i = 0; i < 16; i++) apb(1'b1, IDX_SIG_BASE + 6'(i), ALL_ONES, 1'b0);
    measure(8'h21, 8'h00, 2);
    check(marks, b + 16, "slot sixteen registers");
    measure(8'h01, 8'h00, 2);
    check(marks, b, "slot sixteen serial");
    measure(8'h03, 8'h02, 16);
    check(marks, 8 * b + 2, "automatic ebits");
    $display("Test frame content done");
    wrap_up();
  end
endmodule
